// ===== inc/bsc_pkg.sv
// constants shared by the banked channel memory system
package bsc_pkg;
  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int BSC_NUM_CH = 8;
  localparam int BSC_BANKS = 42;
  localparam int BSC_WORDS = 2048;
  localparam int BSC_WORD_W = 72;
  localparam int BSC_ECC_DATA_W = 64;
  localparam int BSC_CHK_W = 8;
  localparam int BSC_HAM_W = 7;
  localparam int BSC_WSEL_W = 11;
  localparam int BSC_BSEL_W = 6;
  localparam int BSC_ADDR_W = 17;
  localparam logic [5:0] BSC_BANK_MAX = 6'h29;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int BSC_MEM_FREQ_MAX_MHZ = 750;
  localparam int BSC_RD_LAT_NORM = 12;
  localparam int BSC_RD_LAT_LP = 13;
  localparam int BSC_WR_LAT = 1;
  // stages between the array output register and the output register
  localparam int BSC_PIPE = BSC_RD_LAT_LP - 3;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int BSC_AV_ADDR_W = 4;
  localparam logic [3:0] BSC_REG_CTRL = 4'h0;
  localparam logic [3:0] BSC_REG_BANKS = 4'h4;
  localparam logic [3:0] BSC_REG_STAT = 4'h8;
  localparam int BSC_CTRL_EN_LSB = 0;
  localparam int BSC_CTRL_ECC = 8;
  localparam int BSC_CTRL_FWD = 9;
  localparam int BSC_CTRL_LP = 10;
  localparam int BSC_CTRL_LOCK = 31;
  localparam int BSC_BANKS_LSB = 0;
  localparam int BSC_STAT_DET_LSB = 0;
  localparam int BSC_STAT_COR_LSB = 8;
  localparam int BSC_STAT_LOCK = 16;
  localparam logic [7:0] BSC_RST_CH_EN = 8'hFF;
  localparam logic [5:0] BSC_RST_BANKS = 6'h2A;
endpackage : bsc_pkg

// ===== rtl/bsc_ecc.sv
// extended hamming encoder and decoder, combinational
`timescale 1ns/1ps
module bsc_ecc
  import bsc_pkg::*;
(
  input wire logic [BSC_ECC_DATA_W-1:0] enc_data_i,
  input wire logic enc_bypass_i,
  input wire logic [BSC_CHK_W-1:0] enc_chk_i,
  output logic [BSC_WORD_W-1:0] enc_word_o,
  input wire logic [BSC_WORD_W-1:0] dec_word_i,
  output logic [BSC_ECC_DATA_W-1:0] dec_data_o,
  output logic dec_detect_o,
  output logic dec_correct_o
);
  // code position of data bit idx: skips powers of two
  function automatic logic [BSC_HAM_W-1:0] bsc_pos(input int idx);
    int n;
    bsc_pos = '0;
    n = 0;
    for (int q = 3; q < BSC_WORD_W; q++) begin
      if ((q & (q - 1)) != 0) begin
        if (n == idx) bsc_pos = BSC_HAM_W'(q);
        n++;
      end
    end
  endfunction : bsc_pos

  function automatic logic [BSC_HAM_W-1:0] bsc_ham(input logic [BSC_ECC_DATA_W-1:0] d);
    logic [BSC_HAM_W-1:0] pos;
    logic [BSC_HAM_W-1:0] h;
    h = '0;
    for (int i = 0; i < BSC_ECC_DATA_W; i++) begin
      pos = bsc_pos(i);
      for (int k = 0; k < BSC_HAM_W; k++) begin
        if (pos[k]) h[k] = h[k] ^ d[i];
      end
    end
    return h;
  endfunction : bsc_ham

  logic [BSC_HAM_W-1:0] enc_h;
  logic [BSC_HAM_W-1:0] syn;
  logic ovr;

  always_comb begin
    enc_h = bsc_ham(enc_data_i);
    if (enc_bypass_i) begin
      enc_word_o = {enc_chk_i, enc_data_i};
    end else begin
      enc_word_o = {(^enc_data_i) ^ (^enc_h), enc_h, enc_data_i};
    end
  end

  always_comb begin
    syn = bsc_ham(dec_word_i[BSC_ECC_DATA_W-1:0]) ^ dec_word_i[BSC_WORD_W-2:BSC_ECC_DATA_W];
    ovr = ^dec_word_i;
    dec_data_o = dec_word_i[BSC_ECC_DATA_W-1:0];
    // odd overall parity: one flipped bit, fix it; even with syndrome: two bits
    if (ovr) begin
      for (int i = 0; i < BSC_ECC_DATA_W; i++) begin
        if (bsc_pos(i) == syn) dec_data_o[i] = ~dec_word_i[i];
      end
    end
    dec_detect_o = ovr || (syn != '0);
    dec_correct_o = ovr;
  end
endmodule : bsc_ecc

// ===== rtl/bsc_bank_array.sv
// channel bank storage, one write and one read port, no reset
`timescale 1ns/1ps
module bsc_bank_array #(
  parameter int DEPTH = 86016,
  parameter int WIDTH = 72,
  parameter int AW = 17
) (
  input wire logic core_clk_i,
  input wire logic wr_en_i,
  input wire logic [AW-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [AW-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rd_data;
  } bsc_bank_state_t;

  bsc_bank_state_t r;
  bsc_bank_state_t nxt_r;

  always_comb begin
    nxt_r = r;
    if (rd_en_i) nxt_r.rd_data = r.mem[rd_addr_i];
    if (wr_en_i) nxt_r.mem[wr_addr_i] = wr_data_i;
  end

  // array has no reset at all
  always_ff @(posedge core_clk_i) begin
    r <= nxt_r;
  end

  assign rd_data_o = r.rd_data;
endmodule : bsc_bank_array

// ===== rtl/bsc_channel_sys.sv
// eight channel banked memory system with avalon configuration slave
`timescale 1ns/1ps
module bsc_channel_sys
  import bsc_pkg::*;
#(
  parameter int NUM_CH = BSC_NUM_CH,
  parameter int BANKS = BSC_BANKS
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_wr_data_i,
  input wire logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_wr_addr_i,
  input wire logic [NUM_CH-1:0] ch_wr_n_i,
  input wire logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_rd_addr_i,
  input wire logic [NUM_CH-1:0] ch_rd_n_i,
  input wire logic [NUM_CH-1:0] ch_enc_bypass_i,
  output logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_rd_data_o,
  output logic [NUM_CH-1:0] ch_rd_valid_o,
  output logic [NUM_CH-1:0] ch_err_detect_o,
  output logic [NUM_CH-1:0] ch_err_correct_o,
  input wire logic [BSC_AV_ADDR_W-1:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [31:0] av_writedata_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o
);
  // ****************************************************************
  // state
  // ****************************************************************
  localparam logic [BSC_BSEL_W-1:0] BANKS_CODE = BSC_BSEL_W'(BANKS);
  localparam int DEPTH = BANKS * BSC_WORDS;

  typedef struct packed {
    logic v;
    logic [BSC_WORD_W-1:0] data;
    logic det;
    logic cor;
  } bsc_stage_t;

  typedef struct packed {
    logic wr_v;
    logic [BSC_ADDR_W-1:0] wr_addr;
    logic [BSC_WORD_W-1:0] wr_word;
    logic rd_v;
    logic [BSC_ADDR_W-1:0] rd_addr;
    logic rd_live;
    logic rd_fwd;
    logic m_v;
    logic m_live;
    logic m_fwd;
    logic [BSC_WORD_W-1:0] m_fword;
    bsc_stage_t [BSC_PIPE-1:0] pipe;
    bsc_stage_t out;
  } bsc_chan_t;

  typedef struct packed {
    logic [NUM_CH-1:0] ch_en;
    logic ecc_en;
    logic fwd_en;
    logic lp_en;
    logic [BSC_BSEL_W-1:0] banks;
    logic locked;
    logic [NUM_CH-1:0] st_det;
    logic [NUM_CH-1:0] st_cor;
    logic av_wait;
    logic [31:0] av_rdata;
    bsc_chan_t [NUM_CH-1:0] ch;
  } bsc_top_t;

  function automatic bsc_top_t bsc_rst_val();
    bsc_top_t v;
    v = '0;
    v.ch_en = BSC_RST_CH_EN[NUM_CH-1:0];
    v.banks = BSC_RST_BANKS;
    v.av_wait = 1'b1;
    return v;
  endfunction : bsc_rst_val

  localparam bsc_top_t RST_VAL = bsc_rst_val();

  // bank is powered: inside configured count and a real bank code
  function automatic logic bsc_live(input logic [BSC_ADDR_W-1:0] a, input logic [BSC_BSEL_W-1:0] cnt);
    logic [BSC_BSEL_W-1:0] b;
    b = a[BSC_ADDR_W-1:BSC_WSEL_W];
    return (b < cnt) && (b <= BSC_BANK_MAX) && (b < BANKS_CODE);
  endfunction : bsc_live

  bsc_top_t r;
  bsc_top_t nxt_r;

  logic [NUM_CH-1:0][BSC_WORD_W-1:0] enc_word;
  logic [NUM_CH-1:0][BSC_WORD_W-1:0] mem_q;
  logic [NUM_CH-1:0][BSC_WORD_W-1:0] dec_in;
  logic [NUM_CH-1:0][BSC_ECC_DATA_W-1:0] dec_data;
  logic [NUM_CH-1:0] dec_det;
  logic [NUM_CH-1:0] dec_cor;

  // ****************************************************************
  // per channel storage and codec
  // ****************************************************************
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    bsc_ecc u_ecc (
      .enc_data_i(ch_wr_data_i[c][BSC_ECC_DATA_W-1:0]),
      .enc_bypass_i(ch_enc_bypass_i[c]),
      .enc_chk_i(ch_wr_data_i[c][BSC_WORD_W-1:BSC_ECC_DATA_W]),
      .enc_word_o(enc_word[c]),
      .dec_word_i(dec_in[c]),
      .dec_data_o(dec_data[c]),
      .dec_detect_o(dec_det[c]),
      .dec_correct_o(dec_cor[c])
    );

    // each channel owns a private array
    bsc_bank_array #(
      .DEPTH(DEPTH),
      .WIDTH(BSC_WORD_W),
      .AW(BSC_ADDR_W)
    ) u_banks (
      .core_clk_i(core_clk_i),
      .wr_en_i(r.ch[c].wr_v),
      .wr_addr_i(r.ch[c].wr_addr),
      .wr_data_i(r.ch[c].wr_word),
      .rd_en_i(r.ch[c].rd_v && r.ch[c].rd_live && !r.ch[c].rd_fwd),
      .rd_addr_i(r.ch[c].rd_addr),
      .rd_data_o(mem_q[c])
    );

    // forwarded word replaces the array output
    assign dec_in[c] = r.ch[c].m_fwd ? r.ch[c].m_fword : mem_q[c];
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    bsc_stage_t ent;
    logic [NUM_CH-1:0] set_det;
    logic [NUM_CH-1:0] set_cor;
    logic [NUM_CH-1:0] clr;
    logic [31:0] rv;
    logic go_wr;
    logic go_rd;
    ent = '0;
    set_det = '0;
    set_cor = '0;
    clr = '0;
    rv = '0;
    go_wr = 1'b0;
    go_rd = 1'b0;
    nxt_r = r;

    for (int c = 0; c < NUM_CH; c++) begin
      // interface stage; traffic only once locked and enabled
      go_wr = r.locked && r.ch_en[c] && !ch_wr_n_i[c];
      go_rd = r.locked && r.ch_en[c] && !ch_rd_n_i[c];
      nxt_r.ch[c].wr_v = go_wr && bsc_live(ch_wr_addr_i[c], r.banks);
      nxt_r.ch[c].wr_addr = ch_wr_addr_i[c];
      nxt_r.ch[c].wr_word = r.ecc_en ? enc_word[c] : ch_wr_data_i[c];
      nxt_r.ch[c].rd_v = go_rd;
      nxt_r.ch[c].rd_addr = ch_rd_addr_i[c];
      nxt_r.ch[c].rd_live = bsc_live(ch_rd_addr_i[c], r.banks);
      nxt_r.ch[c].rd_fwd = r.fwd_en && go_wr && go_rd && (ch_wr_addr_i[c] == ch_rd_addr_i[c]);

      // array stage
      nxt_r.ch[c].m_v = r.ch[c].rd_v;
      nxt_r.ch[c].m_live = r.ch[c].rd_live || r.ch[c].rd_fwd;
      nxt_r.ch[c].m_fwd = r.ch[c].rd_fwd;
      nxt_r.ch[c].m_fword = r.ch[c].wr_word;

      // decoded entry into the delay line
      ent.v = r.ch[c].m_v;
      if (!r.ch[c].m_live) begin
        ent.data = '0;
      end else if (r.ecc_en) begin
        ent.data = {{BSC_CHK_W{1'b0}}, dec_data[c]};
      end else begin
        ent.data = dec_in[c];
      end
      ent.det = r.ch[c].m_v && r.ch[c].m_live && r.ecc_en && dec_det[c];
      ent.cor = r.ch[c].m_v && r.ch[c].m_live && r.ecc_en && dec_cor[c];

      // low power enters one stage earlier, adding one cycle
      nxt_r.ch[c].pipe[0] = r.lp_en ? ent : '0;
      nxt_r.ch[c].pipe[1] = r.lp_en ? r.ch[c].pipe[0] : ent;
      for (int j = 2; j < BSC_PIPE; j++) begin
        nxt_r.ch[c].pipe[j] = r.ch[c].pipe[j-1];
      end

      // output stage holds data between reads
      if (r.ch[c].pipe[BSC_PIPE-1].v) begin
        nxt_r.ch[c].out = r.ch[c].pipe[BSC_PIPE-1];
      end else begin
        nxt_r.ch[c].out.v = 1'b0;
        nxt_r.ch[c].out.det = 1'b0;
        nxt_r.ch[c].out.cor = 1'b0;
      end
      set_det[c] = nxt_r.ch[c].out.det;
      set_cor[c] = nxt_r.ch[c].out.cor;
    end

    // ****************************************************************
    // avalon slave: one wait cycle, write applied on the release edge
    // ****************************************************************
    case (av_address_i)
      BSC_REG_CTRL: begin
        rv[BSC_CTRL_EN_LSB +: NUM_CH] = r.ch_en;
        rv[BSC_CTRL_ECC] = r.ecc_en;
        rv[BSC_CTRL_FWD] = r.fwd_en;
        rv[BSC_CTRL_LP] = r.lp_en;
        rv[BSC_CTRL_LOCK] = r.locked;
      end
      BSC_REG_BANKS: begin
        rv[BSC_BANKS_LSB +: BSC_BSEL_W] = r.banks;
      end
      BSC_REG_STAT: begin
        rv[BSC_STAT_DET_LSB +: NUM_CH] = r.st_det;
        rv[BSC_STAT_COR_LSB +: NUM_CH] = r.st_cor;
        rv[BSC_STAT_LOCK] = r.locked;
      end
      default: begin
        rv = '0;
      end
    endcase

    if ((av_read_i || av_write_i) && r.av_wait) begin
      nxt_r.av_wait = 1'b0;
      nxt_r.av_rdata = av_read_i ? rv : r.av_rdata;
    end else if (!r.av_wait) begin
      nxt_r.av_wait = 1'b1;
      if (av_write_i) begin
        case (av_address_i)
          BSC_REG_CTRL: begin
            if (!r.locked) begin
              nxt_r.ch_en = av_writedata_i[BSC_CTRL_EN_LSB +: NUM_CH];
              nxt_r.ecc_en = av_writedata_i[BSC_CTRL_ECC];
              nxt_r.fwd_en = av_writedata_i[BSC_CTRL_FWD];
              nxt_r.lp_en = av_writedata_i[BSC_CTRL_LP];
              nxt_r.locked = av_writedata_i[BSC_CTRL_LOCK];
            end
          end
          BSC_REG_BANKS: begin
            if (!r.locked) nxt_r.banks = av_writedata_i[BSC_BANKS_LSB +: BSC_BSEL_W];
          end
          BSC_REG_STAT: begin
            clr = av_writedata_i[BSC_STAT_DET_LSB +: NUM_CH] | av_writedata_i[BSC_STAT_COR_LSB +: NUM_CH];
          end
          default: begin
            clr = '0;
          end
        endcase
      end
    end

    // sticky flags: a new event wins over a clear
    nxt_r.st_det = (r.st_det & ~(av_write_i && !r.av_wait && av_address_i == BSC_REG_STAT ?
      av_writedata_i[BSC_STAT_DET_LSB +: NUM_CH] : {NUM_CH{1'b0}})) | set_det;
    nxt_r.st_cor = (r.st_cor & ~(av_write_i && !r.av_wait && av_address_i == BSC_REG_STAT ?
      av_writedata_i[BSC_STAT_COR_LSB +: NUM_CH] : {NUM_CH{1'b0}})) | set_cor;
    if (clr == '1) nxt_r.av_rdata = r.av_rdata;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      r <= RST_VAL;
    end else begin
      r <= nxt_r;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  for (genvar c = 0; c < NUM_CH; c++) begin : g_out
    assign ch_rd_data_o[c] = r.ch[c].out.data;
    assign ch_rd_valid_o[c] = r.ch[c].out.v;
    assign ch_err_detect_o[c] = r.ch[c].out.det;
    assign ch_err_correct_o[c] = r.ch[c].out.cor;
  end

  assign av_readdata_o = r.av_rdata;
  assign av_waitrequest_o = r.av_wait;
endmodule : bsc_channel_sys

// ===== bench/bsc_channel_sva.sv
// assertion checker for the banked channel memory system, channel 0 and config slave
`timescale 1ns/1ps
module bsc_channel_sva
  import bsc_pkg::*;
#(
  parameter int NUM_CH = BSC_NUM_CH,
  parameter int BANKS = BSC_BANKS
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_wr_data_i,
  input wire logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_wr_addr_i,
  input wire logic [NUM_CH-1:0] ch_wr_n_i,
  input wire logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_rd_addr_i,
  input wire logic [NUM_CH-1:0] ch_rd_n_i,
  input wire logic [NUM_CH-1:0] ch_enc_bypass_i,
  input wire logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_rd_data_o,
  input wire logic [NUM_CH-1:0] ch_rd_valid_o,
  input wire logic [NUM_CH-1:0] ch_err_detect_o,
  input wire logic [NUM_CH-1:0] ch_err_correct_o,
  input wire logic [BSC_AV_ADDR_W-1:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [31:0] av_writedata_i,
  input wire logic [31:0] av_readdata_o,
  input wire logic av_waitrequest_o
);
  // ****************************************************************
  // configuration shadow
  // ****************************************************************
  typedef struct packed {
    logic lock;
    logic ecc;
    logic lp;
    logic en0;
  } bsc_chk_state_t;
  bsc_chk_state_t st_ff;
  bsc_chk_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    if (av_write_i && !av_waitrequest_o && av_address_i == BSC_REG_CTRL && !st_ff.lock) begin
      nxt_st.lock = av_writedata_i[BSC_CTRL_LOCK];
      nxt_st.ecc = av_writedata_i[BSC_CTRL_ECC];
      nxt_st.lp = av_writedata_i[BSC_CTRL_LP];
      nxt_st.en0 = av_writedata_i[BSC_CTRL_EN_LSB];
    end
  end
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_ff <= 4'h1;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_rd_req;
    st_ff.lock && st_ff.en0 && !ch_rd_n_i[0];
  endsequence
  sequence s_av_req;
    (av_read_i || av_write_i) && av_waitrequest_o;
  endsequence
  property p_rd_lat_norm;
    s_rd_req and !st_ff.lp |-> ##12 ch_rd_valid_o[0];
  endproperty
  property p_rd_lat_lp;
    s_rd_req and st_ff.lp |-> ##13 ch_rd_valid_o[0];
  endproperty
  property p_valid_cause;
    ch_rd_valid_o[0] |-> !$past(ch_rd_n_i[0], 12) || !$past(ch_rd_n_i[0], 13);
  endproperty
  property p_rd_hold;
    !ch_rd_valid_o[0] |-> $stable(ch_rd_data_o[0]);
  endproperty
  property p_flags_with_valid;
    ch_err_detect_o[0] || ch_err_correct_o[0] |-> ch_rd_valid_o[0];
  endproperty
  property p_cor_det;
    ch_err_correct_o[0] |-> ch_err_detect_o[0];
  endproperty
  property p_ecc_off_quiet;
    !st_ff.ecc |-> !ch_err_detect_o[0] && !ch_err_correct_o[0];
  endproperty
  property p_ecc_upper;
    st_ff.ecc && ch_rd_valid_o[0] |-> ch_rd_data_o[0][71:64] == 8'h00;
  endproperty
  property p_wait_one;
    s_av_req |=> !av_waitrequest_o;
  endproperty
  property p_ctrl_frozen;
    av_read_i && !av_waitrequest_o && av_address_i == BSC_REG_CTRL && st_ff.lock |-> av_readdata_o[31];
  endproperty
  a_rd_lat_norm: assert property (p_rd_lat_norm) else $error("read data late or missing");
  a_rd_lat_lp: assert property (p_rd_lat_lp) else $error("low power read data late or missing");
  a_valid_cause: assert property (p_valid_cause) else $error("read valid without request");
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
  a_flags_with_valid: assert property (p_flags_with_valid) else $error("error flag outside read");
  a_cor_det: assert property (p_cor_det) else $error("correct without detect");
  a_ecc_off_quiet: assert property (p_ecc_off_quiet) else $error("error flag with ecc off");
  a_ecc_upper: assert property (p_ecc_upper) else $error("upper read bits not zero with ecc");
  a_wait_one: assert property (p_wait_one) else $error("register answer not after one wait");
  a_ctrl_frozen: assert property (p_ctrl_frozen) else $error("lock bit lost");
endmodule : bsc_channel_sva

bind bsc_channel_sys bsc_channel_sva #(.NUM_CH(NUM_CH), .BANKS(BANKS)) u_sva (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .ch_wr_data_i(ch_wr_data_i), .ch_wr_addr_i(ch_wr_addr_i),
  .ch_wr_n_i(ch_wr_n_i), .ch_rd_addr_i(ch_rd_addr_i), .ch_rd_n_i(ch_rd_n_i), .ch_enc_bypass_i(ch_enc_bypass_i),
  .ch_rd_data_o(ch_rd_data_o), .ch_rd_valid_o(ch_rd_valid_o), .ch_err_detect_o(ch_err_detect_o),
  .ch_err_correct_o(ch_err_correct_o), .av_address_i(av_address_i), .av_read_i(av_read_i),
  .av_write_i(av_write_i), .av_writedata_i(av_writedata_i), .av_readdata_o(av_readdata_o),
  .av_waitrequest_o(av_waitrequest_o));

// ===== bench/bsc_user_model.sv
// user core logic model driving the channel request ports
`timescale 1ns/1ps
module bsc_user_model
  import bsc_pkg::*;
#(
  parameter int NUM_CH = 2
) (
  input wire logic core_clk_i,
  output logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_wr_data_o,
  output logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_wr_addr_o,
  output logic [NUM_CH-1:0] ch_wr_n_o,
  output logic [NUM_CH-1:0][BSC_ADDR_W-1:0] ch_rd_addr_o,
  output logic [NUM_CH-1:0] ch_rd_n_o,
  output logic [NUM_CH-1:0] ch_enc_bypass_o,
  input wire logic [NUM_CH-1:0][BSC_WORD_W-1:0] ch_rd_data_i,
  input wire logic [NUM_CH-1:0] ch_rd_valid_i
);
  initial begin
    ch_wr_data_o = '0;
    ch_wr_addr_o = '0;
    ch_rd_addr_o = '0;
    ch_wr_n_o = '1;
    ch_rd_n_o = '1;
    ch_enc_bypass_o = '0;
  end
  // one cycle of optional write and optional read, then wait for read data
  task automatic xfer(input int ch, input logic wr, input logic [16:0] wa, input logic [71:0] wd,
                      input logic byp, input logic rd, input logic [16:0] ra, output logic [71:0] q,
                      output int lat);
    lat = 99;
    q = '0;
    @(posedge core_clk_i);
    ch_wr_n_o[ch] <= !wr;
    ch_rd_n_o[ch] <= !rd;
    ch_wr_addr_o[ch] <= wa;
    ch_rd_addr_o[ch] <= ra;
    ch_wr_data_o[ch] <= wd;
    ch_enc_bypass_o[ch] <= byp;
    for (int n = 1; n <= 40; n++) begin
      @(posedge core_clk_i);
      if (n == 1) begin
        ch_wr_n_o[ch] <= 1'h1;
        ch_rd_n_o[ch] <= 1'h1;
        // released address and data lines show the inverse, never the last value; bypass returns to 0
        ch_wr_addr_o[ch] <= ~wa;
        ch_rd_addr_o[ch] <= ~ra;
        ch_wr_data_o[ch] <= ~wd;
        ch_enc_bypass_o[ch] <= 1'h0;
        if (!rd) break;
      end
      if (ch_rd_valid_i[ch] === 1'h1) begin
        lat = n - 1;
        q = ch_rd_data_i[ch];
        break;
      end
    end
  endtask : xfer
endmodule : bsc_user_model

// ===== bench/testbench.sv
// self-checking bench for the banked channel memory system
`timescale 1ns/1ps
module testbench;
  import bsc_pkg::*;
  localparam int NCH = 2;
  typedef struct {int ch; logic [16:0] a; logic [71:0] d;} bsc_row_t;
  bsc_row_t rows[4] = '{'{0, 17'h00005, 72'hA5123456789ABCDEF0}, '{1, 17'h00005, 72'h5A0FEDCBA987654321},
                        '{0, 17'h007FF, 72'hFF00FF00FF00FF00FF}, '{0, 17'h00000, 72'h800000000000000001}};
  logic [7:0] chk_tab[4] = '{8'h00, 8'h01, 8'h80, 8'h03};
  logic core_clk;
  logic reset_n;
  logic [3:0] av_address;
  logic av_read;
  logic av_write;
  logic [31:0] av_writedata;
  logic [31:0] av_readdata;
  logic av_waitrequest;
  logic [NCH-1:0][71:0] wr_data;
  logic [NCH-1:0][16:0] wr_addr;
  logic [NCH-1:0][16:0] rd_addr;
  logic [NCH-1:0] wr_n;
  logic [NCH-1:0] rd_n;
  logic [NCH-1:0] byp;
  logic [NCH-1:0][71:0] rd_data;
  logic [NCH-1:0] rd_valid;
  logic [NCH-1:0] det;
  logic [NCH-1:0] cor;
  logic [71:0] q;
  logic [31:0] rdv;
  int lat;
  int error_cnt = 0;
  int tests_run = 0;
  initial core_clk = 1'h0;
  always #10 core_clk = ~core_clk;
  bsc_channel_sys #(.NUM_CH(NCH), .BANKS(2)) u_dut (
    .core_clk_i(core_clk), .reset_n_i(reset_n), .ch_wr_data_i(wr_data), .ch_wr_addr_i(wr_addr),
    .ch_wr_n_i(wr_n), .ch_rd_addr_i(rd_addr), .ch_rd_n_i(rd_n), .ch_enc_bypass_i(byp), .ch_rd_data_o(rd_data),
    .ch_rd_valid_o(rd_valid), .ch_err_detect_o(det), .ch_err_correct_o(cor), .av_address_i(av_address),
    .av_read_i(av_read), .av_write_i(av_write), .av_writedata_i(av_writedata), .av_readdata_o(av_readdata),
    .av_waitrequest_o(av_waitrequest));
  bsc_user_model #(.NUM_CH(NCH)) u_usr (
    .core_clk_i(core_clk), .ch_wr_data_o(wr_data), .ch_wr_addr_o(wr_addr), .ch_wr_n_o(wr_n),
    .ch_rd_addr_o(rd_addr), .ch_rd_n_o(rd_n), .ch_enc_bypass_o(byp), .ch_rd_data_i(rd_data),
    .ch_rd_valid_i(rd_valid));
  // ****************************************************************
  // compare and bus tasks
  // ****************************************************************
  task automatic chk_data(input string nm, input logic [71:0] exp, input logic [71:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_data
  task automatic chk_flag(input string nm, input logic exp, input logic got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask : chk_flag
  task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    av_address <= a;
    av_writedata <= wd;
    av_write <= wr;
    av_read <= !wr;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (av_waitrequest === 1'h0) break;
    end
    rdv = av_readdata;
    av_write <= 1'h0;
    av_read <= 1'h0;
    if (n == 20) begin
      error_cnt++;
      end_sim();
    end
  endtask : av_xfer
  task automatic av_rd_chk(input logic [3:0] a, input logic [31:0] exp);
    av_xfer(1'h0, a, 32'h0);
    chk_data("register", {40'h0, exp}, {40'h0, rdv});
  endtask : av_rd_chk
  task automatic wr(input int ch, input logic [16:0] a, input logic [71:0] d, input logic b);
    u_usr.xfer(ch, 1'h1, a, d, b, 1'h0, 17'h0, q, lat);
  endtask : wr
  task automatic rd_chk(input int ch, input logic [16:0] a, input logic [71:0] exp, input logic ed,
                        input logic ec, input int el);
    chk_data("read data", exp, q);
    chk_data("read latency", 72'(el), 72'(lat));
    chk_flag("detect", ed, det[ch]);
    chk_flag("correct", ec, cor[ch]);
    if (lat == 99) end_sim();
  endtask : rd_chk
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    reset_n = 1'h0;
    av_address = 4'h0;
    av_read = 1'h0;
    av_write = 1'h0;
    av_writedata = 32'h0;
    repeat (16) @(posedge core_clk);
    chk_flag("waitrequest in reset", 1'h1, av_waitrequest);
    reset_n <= 1'h1;
    av_rd_chk(BSC_REG_CTRL, 32'(BSC_RST_CH_EN[NCH-1:0]));
    av_rd_chk(BSC_REG_BANKS, 32'h0000002A);
    av_rd_chk(4'hC, 32'h0);
    av_xfer(1'h1, BSC_REG_BANKS, 32'h1);
    av_xfer(1'h1, BSC_REG_CTRL, 32'h80000003);
    av_rd_chk(BSC_REG_STAT, 32'h00010000);
    foreach (rows[i]) wr(rows[i].ch, rows[i].a, rows[i].d, 1'h0);
    foreach (rows[i]) begin
      u_usr.xfer(rows[i].ch, 1'h0, 17'h0, 72'h0, 1'h0, 1'h1, rows[i].a, q, lat);
      rd_chk(rows[i].ch, rows[i].a, rows[i].d, 1'h0, 1'h0, 12);
    end
    wr(0, 17'h00800, 72'h123, 1'h0);
    u_usr.xfer(0, 1'h0, 17'h0, 72'h0, 1'h0, 1'h1, 17'h00800, q, lat);
    rd_chk(0, 17'h00800, 72'h0, 1'h0, 1'h0, 12);
    u_usr.xfer(0, 1'h1, 17'h00005, 72'h77, 1'h0, 1'h1, 17'h00005, q, lat);
    rd_chk(0, 17'h00005, rows[0].d, 1'h0, 1'h0, 12);
    u_usr.xfer(0, 1'h0, 17'h0, 72'h0, 1'h0, 1'h1, 17'h00005, q, lat);
    rd_chk(0, 17'h00005, 72'h77, 1'h0, 1'h0, 12);
    av_xfer(1'h1, BSC_REG_CTRL, 32'h00000700);
    av_rd_chk(BSC_REG_CTRL, 32'h80000003);
    av_xfer(1'h1, BSC_REG_BANKS, 32'h2);
    av_rd_chk(BSC_REG_BANKS, 32'h1);
    reset_n <= 1'h0;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'h1;
    av_xfer(1'h1, BSC_REG_CTRL, 32'h80000703);
    wr(1, 17'h00803, {8'h55, 64'h0123456789ABCDEF}, 1'h0);
    u_usr.xfer(1, 1'h0, 17'h0, 72'h0, 1'h0, 1'h1, 17'h00803, q, lat);
    rd_chk(1, 17'h00803, {8'h00, 64'h0123456789ABCDEF}, 1'h0, 1'h0, 13);
    u_usr.xfer(1, 1'h1, 17'h00803, 72'h00CAFE, 1'h0, 1'h1, 17'h00803, q, lat);
    rd_chk(1, 17'h00803, 72'h00CAFE, 1'h0, 1'h0, 13);
    u_usr.xfer(1, 1'h1, 17'h00804, 72'h00BEEF, 1'h0, 1'h1, 17'h00803, q, lat);
    rd_chk(1, 17'h00803, 72'h00CAFE, 1'h0, 1'h0, 13);
    foreach (chk_tab[i]) begin
      wr(0, 17'h00009, {chk_tab[i], 64'h0}, 1'h1);
      u_usr.xfer(0, 1'h0, 17'h0, 72'h0, 1'h0, 1'h1, 17'h00009, q, lat);
      rd_chk(0, 17'h00009, 72'h0, chk_tab[i] != 8'h00, i == 1 || i == 2, 13);
    end
    av_rd_chk(BSC_REG_STAT, 32'h00010101);
    av_xfer(1'h1, BSC_REG_STAT, 32'h00000101);
    av_rd_chk(BSC_REG_STAT, 32'h00010000);
    end_sim();
  end
endmodule : testbench
